// [design/grep_consts.vh]
`ifndef GREP_CONSTS_VH
`define GREP_CONSTS_VH

// number of exception sources
`define GREP_NSRC        6'd34
// target mode codes
`define GREP_MODE_ROOT   2'h0
`define GREP_MODE_GUEST  2'h1
`define GREP_MODE_CUR    2'h2
// guest exception code values
`define GREP_GEXC_GPA    5'h00
`define GREP_GEXC_GVA    5'h01
// fault page field position
`define GREP_PAGE_LSB    13
// source indices, highest priority first
`define GREP_S_COLD      0
`define GREP_S_SOFT      1
`define GREP_S_SSTEP     2
`define GREP_S_DEBUG_INT_PIN      3
`define GREP_S_IDBRK     4
`define GREP_S_NMI       5
`define GREP_S_MCK_RA    6
`define GREP_S_MCK_IA    7
`define GREP_S_MCK_GA    8
`define GREP_S_RINT      9
`define GREP_S_RWATCH    10
`define GREP_S_GINT      11
`define GREP_S_GWATCH    12
`define GREP_S_IBRK      13
`define GREP_S_FWR       14
`define GREP_S_FWG       15
`define GREP_S_FADE      16
`define GREP_S_FREF_G    17
`define GREP_S_FREF_R    18
`define GREP_S_FINV_G    19
`define GREP_S_FINV_R    20
`define GREP_S_FXI_G     21
`define GREP_S_FXI_R     22
`define GREP_S_FCERR     23
`define GREP_S_FBERR     24
`define GREP_S_SDBP      25
`define GREP_S_CPU       26
`define GREP_S_CPU_R     27
`define GREP_S_RI        28
`define GREP_S_RIRED     29
`define GREP_S_GPSI      30
`define GREP_S_HCALL     31
`define GREP_S_GSFC      32
`define GREP_S_GHFC      33
`endif

// [design/grep_prio.v]
`timescale 1ns/1ps
`include "grep_consts.vh"
module grep_prio #(
  parameter N = 34,
  parameter W = 6
) (
  // requests, bit 0 highest
  input  wire [N-1:0] req,
  // winner
  output reg          any,
  output reg  [W-1:0] idx
);
  integer i;
  // lowest index wins
  always @*
  begin
    any = 1'b0;
    idx = {W{1'b0}};
    for (i = N-1; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        any = 1'b1;
        idx = i[W-1:0];
      end
    end
  end
endmodule // grep_prio

// [design/grep_gpa.v]
`timescale 1ns/1ps
`include "grep_consts.vh"
module grep_gpa (
  // guest address path
  input  wire        seg_impl,
  input  wire [31:0] guest_virt_addr,
  input  wire [31:0] seg_addr,
  input  wire        guest_mapped,
  input  wire        gtlb_valid,
  input  wire [31:0] gtlb_pa,
  // result
  output reg  [31:0] guest_phys_addr,
  output reg         gva_only
);
  reg [31:0] after_seg;
  // segmentation first, then guest TLB if mapped
  always @*
  begin
    after_seg = seg_impl ? seg_addr : guest_virt_addr;
    guest_phys_addr = after_seg;
    gva_only = 1'b0;
    if (guest_mapped)
    begin
      if (gtlb_valid)
        guest_phys_addr = gtlb_pa;
      else
      begin
        guest_phys_addr = guest_virt_addr;
        gva_only = 1'b1;
      end
    end
  end
endmodule // grep_gpa

// [design/grep_top.v]
`timescale 1ns/1ps
`include "grep_consts.vh"
module grep_top (
  // clock and reset
  input  wire        CLOCK,
  input  wire        SRST,
  // pin events
  input  wire        COLD_RESET_PIN,
  input  wire        SOFT_RESET_PIN,
  input  wire        NMI_PIN,
  input  wire        DEBUG_INT_PIN,
  input  wire        DEBUG_BREAK_REQ,
  // pipeline events
  input  wire        BOUNDARY,
  input  wire        GUEST_MODE,
  input  wire [33:0] EVT,
  input  wire [31:0] PC,
  input  wire        IS_FETCH_ADDR,
  // fault address path
  input  wire        FAULT_ROOT_TLB,
  input  wire [31:0] FAULT_VADDR,
  input  wire        SEG_IMPL,
  input  wire [31:0] SEG_ADDR,
  input  wire        GUEST_MAPPED,
  input  wire        GTLB_VALID,
  input  wire [31:0] GTLB_PA,
  // AHB-Lite slave
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  // exception outputs
  output reg         EXC_TAKE,
  output reg  [5:0]  EXC_CODE,
  output reg         EXC_TO_ROOT,
  output reg         MODE_SWITCH
);
  //////////////////////////////////////////////////////////////////
  // register offsets
  localparam [7:0] A_CTL   = 8'h00;
  localparam [7:0] A_FVA   = 8'h04;
  localparam [7:0] A_EPC   = 8'h08;
  localparam [7:0] A_EHI   = 8'h0C;
  localparam [7:0] A_CAUSE = 8'h10;
  localparam [7:0] A_CTX   = 8'h14;
  localparam [7:0] A_RFVA  = 8'h18;

  // pin synchronisers
  reg [4:0] sync1;
  reg [4:0] sync2;
  always @(posedge CLOCK)
  begin
    if (SRST)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end
    else
    begin
      sync1 <= {DEBUG_BREAK_REQ, DEBUG_INT_PIN, NMI_PIN, SOFT_RESET_PIN, COLD_RESET_PIN};
      sync2 <= sync1;
    end
  end

  //////////////////////////////////////////////////////////////////
  // software state
  reg        ri_redirect_en;
  reg [31:0] fault_vaddr_reg;
  reg [31:0] exc_return_pc;
  reg [31:0] tlb_entry_high;
  reg [5:0]  cause;
  reg [18:0] ctx_fault_page;
  reg [31:0] root_fault_vaddr;
  reg [4:0]  guest_exc_code;
  reg        exc_level_bit;
  // bus data-phase write strobe and latched offset
  reg        hw_en;
  reg [7:0]  addr_q;

  //////////////////////////////////////////////////////////////////
  // request vector in priority order
  reg [33:0] req;
  always @*
  begin
    req = EVT;
    req[`GREP_S_COLD] = sync2[0];
    req[`GREP_S_SOFT] = sync2[1];
    req[`GREP_S_NMI]  = sync2[2];
    req[`GREP_S_DEBUG_INT_PIN] = sync2[3] | sync2[4] | EVT[`GREP_S_DEBUG_INT_PIN];
    req[`GREP_S_FADE] = IS_FETCH_ADDR & (PC[1:0] != 2'h0);
    req[`GREP_S_GINT] = EVT[`GREP_S_GINT] & GUEST_MODE;
    req[`GREP_S_GWATCH] = EVT[`GREP_S_GWATCH] & GUEST_MODE;
    if (ri_redirect_en & GUEST_MODE & EVT[`GREP_S_RI])
    begin
      req[`GREP_S_RIRED] = 1'b1;
      req[`GREP_S_RI] = 1'b0;
    end
    req[`GREP_S_RI] = req[`GREP_S_RI] & ~EVT[`GREP_S_CPU] & ~EVT[`GREP_S_CPU_R];
  end

  wire       any;
  wire [5:0] win;
  grep_prio #(.N(34), .W(6)) u_prio (
    .req (req),
    .any (any),
    .idx (win)
  );

  // target mode per source
  function [1:0] mode_of;
    input [5:0] s;
    begin
      case (s)
        `GREP_S_MCK_GA, `GREP_S_GINT, `GREP_S_GWATCH, `GREP_S_FWG,
        `GREP_S_FREF_G, `GREP_S_FINV_G, `GREP_S_FXI_G:
          mode_of = `GREP_MODE_GUEST;
        `GREP_S_FADE, `GREP_S_CPU, `GREP_S_RI:
          mode_of = `GREP_MODE_CUR;
        default:
          mode_of = `GREP_MODE_ROOT;
      endcase
    end
  endfunction

  wire [1:0] win_mode  = mode_of(win);
  wire       to_root   = (win_mode == `GREP_MODE_ROOT) | ((win_mode == `GREP_MODE_CUR) & ~GUEST_MODE);
  wire       is_async  = (win <= 6'd12);
  wire       take      = any & (BOUNDARY | is_async);
  wire       addr_exc  = (win == `GREP_S_FADE) | (win >= `GREP_S_FREF_G && win <= `GREP_S_FXI_R);

  wire [31:0] gpa;
  wire        gva_only;
  grep_gpa u_gpa (
    .seg_impl        (SEG_IMPL),
    .guest_virt_addr (FAULT_VADDR),
    .seg_addr        (SEG_ADDR),
    .guest_mapped    (GUEST_MAPPED),
    .gtlb_valid      (GTLB_VALID),
    .gtlb_pa         (GTLB_PA),
    .guest_phys_addr (gpa),
    .gva_only        (gva_only)
  );

  wire root_tlb_guest = GUEST_MODE & FAULT_ROOT_TLB & to_root;
  wire [31:0] save_addr = root_tlb_guest ? gpa : FAULT_VADDR;

  //////////////////////////////////////////////////////////////////
  // exception take and state save
  always @(posedge CLOCK)
  begin
    if (SRST)
    begin
      EXC_TAKE        <= 1'b0;
      EXC_CODE        <= 6'h00;
      EXC_TO_ROOT     <= 1'b0;
      MODE_SWITCH     <= 1'b0;
      fault_vaddr_reg <= 32'h00000000;
      exc_return_pc   <= 32'h00000000;
      tlb_entry_high  <= 32'h00000000;
      cause           <= 6'h00;
      ctx_fault_page  <= 19'h00000;
      root_fault_vaddr <= 32'h00000000;
      guest_exc_code  <= `GREP_GEXC_GPA;
      exc_level_bit   <= 1'b0;
    end
    else
    begin
      EXC_TAKE    <= take;
      EXC_CODE    <= win;
      EXC_TO_ROOT <= take & to_root;
      MODE_SWITCH <= take & to_root & GUEST_MODE;
      if (take)
      begin
        // root context selected in the same cycle as the save below
        cause         <= win;
        exc_return_pc <= PC;
        if (to_root)
          exc_level_bit <= 1'b1;
        if (addr_exc)
        begin
          fault_vaddr_reg <= save_addr;
          if (root_tlb_guest)
          begin
            root_fault_vaddr <= save_addr;
            tlb_entry_high   <= {save_addr[31:13], 13'h0000};
            ctx_fault_page   <= save_addr[31:`GREP_PAGE_LSB];
            guest_exc_code   <= gva_only ? `GREP_GEXC_GVA : `GREP_GEXC_GPA;
          end
        end
      end
      if (hw_en & (addr_q == A_CTL))
        exc_level_bit <= HWDATA[1] | (take & to_root);
    end
  end

  //////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  wire       acc = HSEL & HTRANS[1] & HREADY;
  always @(posedge CLOCK)
  begin
    if (SRST)
    begin
      hw_en     <= 1'b0;
      addr_q    <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h00000000;
    end
    else
    begin
      hw_en     <= acc & HWRITE;
      addr_q    <= HADDR[7:0];
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (acc & ~HWRITE)
      begin
        case (HADDR[7:0])
          A_CTL:   HRDATA <= {27'h0000000, guest_exc_code[0], 2'h0, exc_level_bit, ri_redirect_en};
          A_FVA:   HRDATA <= fault_vaddr_reg;
          A_EPC:   HRDATA <= exc_return_pc;
          A_EHI:   HRDATA <= tlb_entry_high;
          A_CAUSE: HRDATA <= {26'h0000000, cause};
          A_CTX:   HRDATA <= {ctx_fault_page, 13'h0000};
          A_RFVA:  HRDATA <= root_fault_vaddr;
          default: HRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // redirect control is software written
  always @(posedge CLOCK)
  begin
    if (SRST)
      ri_redirect_en <= 1'b0;
    else if (hw_en & (addr_q == A_CTL))
      ri_redirect_en <= HWDATA[0];
  end
endmodule // grep_top

// [tb/grep_properties.sv]
`timescale 1ns/1ps
module grep_chk (
  // clock and reset
  input wire        CLOCK,
  input wire        SRST,
  // event inputs
  input wire        COLD_RESET_PIN,
  input wire        SOFT_RESET_PIN,
  input wire        NMI_PIN,
  input wire        DEBUG_INT_PIN,
  input wire        DEBUG_BREAK_REQ,
  input wire        BOUNDARY,
  input wire        GUEST_MODE,
  input wire [33:0] EVT,
  input wire [31:0] PC,
  input wire        IS_FETCH_ADDR,
  // outputs
  input wire        HREADYOUT,
  input wire        HRESP,
  input wire        EXC_TAKE,
  input wire [5:0]  EXC_CODE,
  input wire        EXC_TO_ROOT,
  input wire        MODE_SWITCH
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // 0 root, 1 guest, 2 current, 3 unchecked
  function automatic logic [1:0] md(input logic [5:0] c);
    case (c)
      6'h08, 6'h0B, 6'h0C, 6'h0F, 6'h11, 6'h13, 6'h15: md = 2'h1;
      6'h10, 6'h1A, 6'h1C: md = 2'h2;
      6'h18: md = 2'h3;
      default: md = 2'h0;
    endcase
  endfunction
  wire others = !COLD_RESET_PIN && !SOFT_RESET_PIN && !DEBUG_INT_PIN && !DEBUG_BREAK_REQ;
  wire quiet  = others && !NMI_PIN;
  sequence calm;
    quiet[*4];
  endsequence
  chk_sstep_first: assert property (calm ##0 EVT[2] |=> EXC_TAKE && EXC_CODE == 6'h02)
    else $error("single step lost");
  chk_ibrk_first: assert property (calm ##0 BOUNDARY && EVT[14:13] == 2'h3 && EVT[12:2] == 11'h000
    |=> EXC_TAKE && EXC_CODE == 6'h0D) else $error("instruction break lost");
  chk_fetch_align: assert property (calm ##0 BOUNDARY && EVT == 34'h0 && IS_FETCH_ADDR && PC[1:0] != 2'h0
    |=> EXC_TAKE && EXC_CODE == 6'h10) else $error("misaligned fetch missed");
  chk_idle_quiet: assert property (calm ##0 EVT == 34'h0 && !IS_FETCH_ADDR |=> !EXC_TAKE)
    else $error("take without cause");
  chk_nmi_taken: assert property ($rose(NMI_PIN) && others |-> ##[1:6] EXC_TAKE && EXC_CODE == 6'h05)
    else $error("nmi not taken");
  chk_exc_mode: assert property (EXC_TAKE && md(EXC_CODE) != 2'h3 |-> EXC_TO_ROOT ==
    (md(EXC_CODE) == 2'h0 || (md(EXC_CODE) == 2'h2 && !$past(GUEST_MODE)))) else $error("wrong mode");
  chk_sync_boundary: assert property (EXC_TAKE && EXC_CODE > 6'h0C |-> $past(BOUNDARY))
    else $error("sync take off boundary");
  chk_switch_first: assert property (EXC_TAKE && EXC_TO_ROOT && $past(GUEST_MODE) |-> MODE_SWITCH)
    else $error("no mode switch");
  chk_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus wait or error");
endmodule // grep_chk

bind grep_top grep_chk u_chk (.*);

// [tb/grep_src.sv]
`timescale 1ns/1ps
module grep_src (
  // clock
  input wire        clock,
  // pipeline side
  output reg        boundary,
  output reg        guest_mode,
  output reg [33:0] evt,
  output reg [31:0] pc,
  output reg        is_fetch_addr
);
  initial
  begin
    boundary = 1'b1;
    guest_mode = 1'b0;
    evt = 34'h0;
    pc = 32'h00000100;
    is_fetch_addr = 1'b0;
  end
  // one-cycle condition at a boundary
  task post(input logic [33:0] e, input logic g, input logic [31:0] p, input logic f);
  begin
    @(posedge clock);
    evt <= e;
    guest_mode <= g;
    pc <= p;
    is_fetch_addr <= f;
    @(posedge clock);
    evt <= 34'h0;
    is_fetch_addr <= 1'b0;
  end
  endtask
endmodule // grep_src

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [33:0] e; logic g; logic [5:0] c; logic r;} grep_row_t;
  reg         CLOCK = 1'b0;
  reg         SRST = 1'b1;
  reg  [4:0]  pin = 5'h00;
  reg         rtlb = 1'b0;
  reg         mapped = 1'b0;
  reg         gok = 1'b0;
  reg  [31:0] gpa = 32'h0;
  reg  [31:0] fva = 32'h0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire [33:0] evt;
  wire [31:0] pc;
  wire [5:0]  code;
  wire        hready, bnd, gm, fa, take, troot;
  int         n_fail = 0;
  int         checks = 0;
  int         cyc = 0;
  logic [31:0] d;
  grep_row_t  rows [28];
  always #10 CLOCK = ~CLOCK;
  grep_src src (.clock(CLOCK), .boundary(bnd), .guest_mode(gm), .evt(evt), .pc(pc), .is_fetch_addr(fa));
  grep_top DUT (.CLOCK(CLOCK), .SRST(SRST), .COLD_RESET_PIN(pin[0]), .SOFT_RESET_PIN(pin[1]), .NMI_PIN(pin[2]),
    .DEBUG_INT_PIN(pin[3]), .DEBUG_BREAK_REQ(pin[4]), .BOUNDARY(bnd), .GUEST_MODE(gm), .EVT(evt), .PC(pc),
    .IS_FETCH_ADDR(fa), .FAULT_ROOT_TLB(rtlb), .FAULT_VADDR(fva), .SEG_IMPL(1'b0), .SEG_ADDR(32'h0),
    .GUEST_MAPPED(mapped), .GTLB_VALID(gok), .GTLB_PA(gpa), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(), .EXC_TAKE(take), .EXC_CODE(code), .EXC_TO_ROOT(troot), .MODE_SWITCH());
  ////////////////////////////////////////////////////////////////////////////////
  function automatic grep_row_t rw(int hi, int lo, bit g, bit r);
    rw.e = (34'h1 << hi) | (lo < 0 ? 34'h0 : 34'h1 << lo);
    rw.g = g;
    rw.c = hi[5:0];
    rw.r = r;
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
  begin
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
  begin
    @(posedge CLOCK);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge CLOCK);
    while (hready !== 1'b1) @(posedge CLOCK);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge CLOCK);
    while (hready !== 1'b1) @(posedge CLOCK);
    d = hrdata;
  end
  endtask
  task expect_exc(input logic [5:0] c, input logic r);
  begin
    #1;
    for (int i = 0; i < 10 && take !== 1'b1; i++)
    begin
      @(posedge CLOCK);
      #1;
    end
    chk("take", take, 1'b1);
    chk("code", code, c);
    chk("root", troot, r);
    repeat (3) @(posedge CLOCK);
  end
  endtask
  task summarize;
  begin
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  always @(posedge CLOCK)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rows = '{rw(2,3,0,1), rw(3,4,0,1), rw(4,6,0,1), rw(6,7,0,1), rw(7,8,0,1), rw(8,9,1,0), rw(9,10,0,1),
      rw(10,11,1,1), rw(11,12,1,0), rw(12,13,1,0), rw(13,14,0,1), rw(14,15,1,1), rw(15,17,1,0), rw(17,18,1,0),
      rw(18,19,1,1), rw(19,20,1,0), rw(20,21,1,1), rw(21,22,1,0), rw(22,23,0,1), rw(23,24,0,1), rw(25,26,0,1),
      rw(26,28,1,0), rw(26,-1,0,1), rw(27,28,1,1), rw(28,-1,1,0), rw(30,31,1,1), rw(31,32,1,1), rw(32,33,1,1)};
    repeat (8) @(posedge CLOCK);
    SRST <= 1'b0;
    bus(1'b0, 32'h0, 32'h0);
    chk("ctl", d, 32'h0);
    bus(1'b1, 32'h1C, 32'hFFFFFFFF);
    bus(1'b0, 32'h1C, 32'h0);
    chk("unmapped", d, 32'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      bus(1'b1, 32'h0, 32'h0);
      src.post(rows[i].e, rows[i].g, 32'h100, 1'b0);
      expect_exc(rows[i].c, rows[i].r);
    end
    $display("priority rows done");
    foreach (rows[i])
    begin
      if (i < 6)
      begin
        @(posedge CLOCK);
        pin <= (i == 2) ? 5'h03 : (5'h01 << (i > 2 ? i - 1 : i));
        expect_exc(i == 3 ? 6'h05 : (i > 3 ? 6'h03 : (i == 1 ? 6'h01 : 6'h00)), 1'b1);
        pin <= 5'h00;
        repeat (6) @(posedge CLOCK);
      end
    end
    $display("pin test done");
    rtlb <= 1'b1;
    fva <= 32'h10000004;
    src.post(34'h1 << 18, 1'b0, 32'h200, 1'b0);
    expect_exc(6'h12, 1'b1);
    bus(1'b0, 32'h04, 32'h0);
    chk("fault va", d, 32'h10000004);
    bus(1'b0, 32'h08, 32'h0);
    chk("return pc", d, 32'h200);
    mapped <= 1'b1;
    gok <= 1'b1;
    gpa <= 32'h00042000;
    src.post(34'h1 << 18, 1'b1, 32'h300, 1'b0);
    expect_exc(6'h12, 1'b1);
    bus(1'b0, 32'h18, 32'h0);
    chk("root fault", d, 32'h00042000);
    bus(1'b0, 32'h10, 32'h0);
    chk("cause", d, 32'h12);
    gok <= 1'b0;
    src.post(34'h1 << 20, 1'b1, 32'h300, 1'b0);
    expect_exc(6'h14, 1'b1);
    bus(1'b0, 32'h0, 32'h0);
    chk("gva flag", d[4], 1'b1);
    rtlb <= 1'b0;
    src.post(34'h0, 1'b1, 32'h302, 1'b1);
    expect_exc(6'h10, 1'b0);
    bus(1'b1, 32'h0, 32'h1);
    src.post(34'h1 << 28, 1'b1, 32'h300, 1'b0);
    expect_exc(6'h1D, 1'b1);
    $display("fault and redirect tests done");
    summarize;
  end
endmodule // tb_top
